// ==== core/rhpc_pkg.sv ====
// Package for the root hub port change logic: register map, bit layout, timing and types
// ****************************************************************
// ****************************************************************
`default_nettype none
package rhpc_pkg;
	localparam int unsigned PORT_COUNT = 2;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned RESET_TIME_MS = 10;
	localparam int unsigned RESUME_TIME_MS = 20;
	localparam int unsigned RESYNC_TIME_MS = 3;
	localparam int unsigned EOP_TIME_NS = 1334;
	localparam int unsigned RESET_CYC = RESET_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned RESUME_CYC = RESUME_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned RESYNC_CYC = RESYNC_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned EOP_CYC = (EOP_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned TMR_W = 21;
	// ****************************************************************
	// Register indexes; byte address is four times the index
	// ****************************************************************
	localparam logic [7:0] IDX_PORT1 = 8'h15;
	localparam logic [7:0] IDX_INT_STAT = 8'h20;
	localparam logic [7:0] IDX_INT_CLR = 8'h21;
	localparam logic [7:0] IDX_INT_EN = 8'h22;
	// ****************************************************************
	// Port word layout
	// ****************************************************************
	localparam int BIT_PRESENT = 0;
	localparam int BIT_ACTIVE = 1;
	localparam int BIT_SUSPEND = 2;
	localparam int BIT_OCUR = 3;
	localparam int BIT_RESET = 4;
	localparam int BIT_POWER = 8;
	localparam int BIT_SLOW = 9;
	localparam int CMD_W = 10;
	localparam int W_EN_CLR = 0;
	localparam int W_EN_SET = 1;
	localparam int W_SUSP_SET = 2;
	localparam int W_SUSP_CLR = 3;
	localparam int W_RST_SET = 4;
	localparam int W_PWR_ON = 8;
	localparam int W_PWR_OFF = 9;
	localparam int CHG_LSB = 16;
	localparam int CHG_W = 5;
	localparam int CHG_ATTACH = 0;
	localparam int CHG_ENLOST = 1;
	localparam int CHG_RESUME = 2;
	localparam int CHG_OCUR = 3;
	localparam int CHG_RESET = 4;
	localparam logic [1:0] ANN_WAIT = 2'h3;
	localparam int SYNC_W = 6 * PORT_COUNT;
	typedef enum {PH_IDLE, PH_RESET, PH_RESUME, PH_EOP, PH_RESYNC} rhpc_phase_t;
	typedef struct packed {
		logic present;
		logic slow;
		logic ocur;
		logic fault;
		logic wake;
	} rhpc_pin_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} rhpc_apb_req_t;
	function automatic logic [ADDR_W-1:0] rhpc_reg_addr(input logic [7:0] idx);
		return {2'h0, idx, 2'h0};
	endfunction
endpackage
`default_nettype wire

// ==== core/rhpc_sync.sv ====
// Two-stage synchroniser for pin inputs
`default_nettype none
module rhpc_sync
#(
	parameter int unsigned W = 1
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cken,
	input wire logic [W-1:0] d,
	output var logic [W-1:0] q
);
	import rhpc_pkg::*;
	logic [W-1:0] s1_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_q <= '0;
			q <= '0;
		end
		else if (cken)
		begin
			s1_q <= d;
			q <= s1_q;
		end
	end
endmodule
`default_nettype wire

// ==== core/rhpc_top.sv ====
// Root hub port change flags, power commands and APB register slave
`default_nettype none
module rhpc_top
#(
	parameter int unsigned RESET_CYCLES = rhpc_pkg::RESET_CYC,
	parameter int unsigned RESUME_CYCLES = rhpc_pkg::RESUME_CYC,
	parameter int unsigned EOP_CYCLES = rhpc_pkg::EOP_CYC,
	parameter int unsigned RESYNC_CYCLES = rhpc_pkg::RESYNC_CYC
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cken,
	input wire rhpc_pkg::rhpc_apb_req_t apb_req,
	output var logic [31:0] prdata,
	output var logic pready,
	output var logic pslverr,
	input wire rhpc_pkg::rhpc_pin_t [rhpc_pkg::PORT_COUNT-1:0] port_pins,
	input wire logic [rhpc_pkg::PORT_COUNT-1:0] fixed_attach_mask,
	input wire logic [rhpc_pkg::PORT_COUNT-1:0] xact_busy,
	output var logic irq,
	output var logic [rhpc_pkg::PORT_COUNT-1:0] port_power,
	output var logic [rhpc_pkg::PORT_COUNT-1:0] port_reset_drive,
	output var logic [rhpc_pkg::PORT_COUNT-1:0] port_resume_drive
);
	import rhpc_pkg::*;

	function automatic logic [TMR_W-1:0] tmr_load(input int unsigned cyc);
		return TMR_W'(cyc - 1);
	endfunction

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	rhpc_pin_t [PORT_COUNT-1:0] pins_s;
	logic [PORT_COUNT-1:0] fixed_s;
	rhpc_sync #(.W(SYNC_W)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.cken(cken),
		.d({fixed_attach_mask, port_pins}),
		.q({fixed_s, pins_s})
	);

	// ****************************************************************
	// Announce after root hub reset, once synchronised straps are valid
	// ****************************************************************
	logic [1:0] ann_cnt_q, ann_cnt_d;
	logic ann_done_q, ann_done_d;
	logic announce_q, announce_d;
	always_comb
	begin
		ann_cnt_d = ann_cnt_q;
		ann_done_d = ann_done_q;
		announce_d = 1'b0;
		if (!ann_done_q)
		begin
			if (ann_cnt_q == ANN_WAIT)
			begin
				announce_d = 1'b1;
				ann_done_d = 1'b1;
			end
			else
				ann_cnt_d = ann_cnt_q + 2'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ann_cnt_q <= '0;
			ann_done_q <= 1'b0;
			announce_q <= 1'b0;
		end
		else if (cken)
		begin
			ann_cnt_q <= ann_cnt_d;
			ann_done_q <= ann_done_d;
			announce_q <= announce_d;
		end
	end

	// ****************************************************************
	// APB decode
	// ****************************************************************
	logic access;
	logic take;
	logic [PORT_COUNT-1:0] wr_hit;
	assign access = apb_req.psel && apb_req.penable;
	// Writes land at the edge that completes the access
	assign take = access && pready;
	always_comb
	begin
		for (int p = 0; p < PORT_COUNT; p++)
			wr_hit[p] = take && apb_req.pwrite
				&& (apb_req.paddr == rhpc_reg_addr(IDX_PORT1 + 8'(p)));
	end

	// ****************************************************************
	// Per-port state
	// ****************************************************************
	logic [PORT_COUNT-1:0] present_q, present_d, active_q, active_d, susp_q, susp_d;
	logic [PORT_COUNT-1:0] rst_q, rst_d, power_q, power_d, slow_q, slow_d;
	logic [PORT_COUNT-1:0] ocur_q, ocur_d, resdrv_q, resdrv_d, evt;
	logic [CHG_W-1:0] chg_q [PORT_COUNT];
	logic [CHG_W-1:0] chg_d [PORT_COUNT];
	logic [CHG_W-1:0] set_a [PORT_COUNT];
	logic [CMD_W-1:0] pend_q [PORT_COUNT];
	logic [CMD_W-1:0] pend_d [PORT_COUNT];
	logic [TMR_W-1:0] tmr_q [PORT_COUNT];
	logic [TMR_W-1:0] tmr_d [PORT_COUNT];
	rhpc_phase_t phase_q [PORT_COUNT];
	rhpc_phase_t phase_d [PORT_COUNT];

	always_comb
	begin
		logic [CMD_W-1:0] cmd;
		logic [CHG_W-1:0] clr_v;
		logic [CHG_W-1:0] set_v;
		cmd = '0;
		clr_v = '0;
		set_v = '0;
		for (int p = 0; p < PORT_COUNT; p++)
		begin
			// Commands wait while the port is busy with a transaction
			cmd = xact_busy[p] ? '0 : pend_q[p];
			pend_d[p] = (xact_busy[p] ? pend_q[p] : '0)
				| (wr_hit[p] ? apb_req.pwdata[CMD_W-1:0] : '0);
			clr_v = wr_hit[p] ? apb_req.pwdata[CHG_LSB +: CHG_W] : '0;
			set_v = '0;
			power_d[p] = power_q[p];
			active_d[p] = active_q[p];
			susp_d[p] = susp_q[p];
			rst_d[p] = rst_q[p];
			phase_d[p] = phase_q[p];
			tmr_d[p] = tmr_q[p];
			present_d[p] = pins_s[p].present && power_q[p];
			slow_d[p] = pins_s[p].slow;
			ocur_d[p] = pins_s[p].ocur;
			if (ocur_d[p] != ocur_q[p])
				set_v[CHG_OCUR] = 1'b1;
			if ((present_d[p] != present_q[p]) && !fixed_s[p])
				set_v[CHG_ATTACH] = 1'b1;
			if (announce_q && fixed_s[p])
				set_v[CHG_ATTACH] = 1'b1;
			if (phase_q[p] != PH_IDLE)
			begin
				if (tmr_q[p] == '0)
				begin
					case (phase_q[p])
						PH_RESET:
						begin
							rst_d[p] = 1'b0;
							active_d[p] = 1'b1;
							set_v[CHG_RESET] = 1'b1;
							phase_d[p] = PH_IDLE;
						end
						PH_RESUME:
						begin
							phase_d[p] = PH_EOP;
							tmr_d[p] = tmr_load(EOP_CYCLES);
						end
						PH_EOP:
						begin
							phase_d[p] = PH_RESYNC;
							tmr_d[p] = tmr_load(RESYNC_CYCLES);
						end
						PH_RESYNC:
						begin
							susp_d[p] = 1'b0;
							set_v[CHG_RESUME] = 1'b1;
							phase_d[p] = PH_IDLE;
						end
						default:
							phase_d[p] = PH_IDLE;
					endcase
				end
				else
					tmr_d[p] = tmr_q[p] - TMR_W'(1);
			end
			if (cmd[W_PWR_ON])
				power_d[p] = 1'b1;
			if (cmd[W_PWR_OFF])
				power_d[p] = 1'b0;
			if (pins_s[p].ocur)
				power_d[p] = 1'b0;
			// Driver disable: no change flag
			if (cmd[W_EN_CLR])
				active_d[p] = 1'b0;
			if (cmd[W_EN_SET])
			begin
				if (present_q[p])
					active_d[p] = 1'b1;
				else
					set_v[CHG_ATTACH] = 1'b1;
			end
			if (cmd[W_SUSP_SET])
			begin
				if (!present_q[p])
					set_v[CHG_ATTACH] = 1'b1;
				else if (active_q[p])
					susp_d[p] = 1'b1;
			end
			if (cmd[W_RST_SET] && (phase_q[p] != PH_RESET))
			begin
				if (present_q[p])
				begin
					rst_d[p] = 1'b1;
					phase_d[p] = PH_RESET;
					tmr_d[p] = tmr_load(RESET_CYCLES);
				end
				else
					set_v[CHG_ATTACH] = 1'b1;
			end
			if ((cmd[W_SUSP_CLR] || pins_s[p].wake) && susp_q[p] && (phase_q[p] == PH_IDLE))
			begin
				phase_d[p] = PH_RESUME;
				tmr_d[p] = tmr_load(RESUME_CYCLES);
			end
			// Disconnect or fault is a hardware loss of enable
			if (active_q[p] && power_q[p] && (pins_s[p].fault || !present_d[p]))
			begin
				active_d[p] = 1'b0;
				set_v[CHG_ENLOST] = 1'b1;
			end
			if (!present_d[p] || !power_d[p])
			begin
				active_d[p] = 1'b0;
				susp_d[p] = 1'b0;
				rst_d[p] = 1'b0;
				phase_d[p] = PH_IDLE;
			end
			// Set wins over a simultaneous clear
			chg_d[p] = (chg_q[p] & ~clr_v) | set_v;
			if (set_v[CHG_RESET])
				chg_d[p][CHG_RESUME] = 1'b0;
			resdrv_d[p] = (phase_d[p] == PH_RESUME);
			set_a[p] = set_v;
			evt[p] = |set_v;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			present_q <= '0;
			active_q <= '0;
			susp_q <= '0;
			rst_q <= '0;
			power_q <= '0;
			slow_q <= '0;
			ocur_q <= '0;
			resdrv_q <= '0;
			for (int p = 0; p < PORT_COUNT; p++)
			begin
				chg_q[p] <= '0;
				pend_q[p] <= '0;
				tmr_q[p] <= '0;
				phase_q[p] <= PH_IDLE;
			end
		end
		else if (cken)
		begin
			present_q <= present_d;
			active_q <= active_d;
			susp_q <= susp_d;
			rst_q <= rst_d;
			power_q <= power_d;
			slow_q <= slow_d;
			ocur_q <= ocur_d;
			resdrv_q <= resdrv_d;
			chg_q <= chg_d;
			pend_q <= pend_d;
			tmr_q <= tmr_d;
			phase_q <= phase_d;
		end
	end
	assign port_power = power_q;
	assign port_reset_drive = rst_q;
	assign port_resume_drive = resdrv_q;

	// ****************************************************************
	// Register read, interrupt status and enable
	// ****************************************************************
	logic [31:0] prdata_d;
	logic pready_d, pslverr_d, irq_d;
	logic [PORT_COUNT-1:0] int_stat_q, int_stat_d, int_en_q, int_en_d;
	always_comb
	begin
		logic [31:0] rd;
		logic mapped;
		rd = '0;
		mapped = 1'b0;
		for (int p = 0; p < PORT_COUNT; p++)
		begin
			if (apb_req.paddr == rhpc_reg_addr(IDX_PORT1 + 8'(p)))
			begin
				mapped = 1'b1;
				rd[BIT_PRESENT] = present_q[p];
				rd[BIT_ACTIVE] = active_q[p];
				rd[BIT_SUSPEND] = susp_q[p];
				rd[BIT_OCUR] = ocur_q[p];
				rd[BIT_RESET] = rst_q[p];
				rd[BIT_POWER] = power_q[p];
				rd[BIT_SLOW] = slow_q[p];
				rd[CHG_LSB +: CHG_W] = chg_q[p];
			end
		end
		if (apb_req.paddr == rhpc_reg_addr(IDX_INT_STAT))
		begin
			mapped = 1'b1;
			rd[PORT_COUNT-1:0] = int_stat_q;
		end
		if (apb_req.paddr == rhpc_reg_addr(IDX_INT_CLR))
			mapped = 1'b1;
		if (apb_req.paddr == rhpc_reg_addr(IDX_INT_EN))
		begin
			mapped = 1'b1;
			rd[PORT_COUNT-1:0] = int_en_q;
		end
		// One wait state; read data captured as pready rises
		pready_d = access && !pready;
		prdata_d = (pready_d && !apb_req.pwrite) ? rd : prdata;
		pslverr_d = pready_d && !mapped;
		int_en_d = int_en_q;
		int_stat_d = int_stat_q;
		if (take && apb_req.pwrite && (apb_req.paddr == rhpc_reg_addr(IDX_INT_EN)))
			int_en_d = apb_req.pwdata[PORT_COUNT-1:0];
		if (take && apb_req.pwrite && (apb_req.paddr == rhpc_reg_addr(IDX_INT_CLR)))
			int_stat_d = int_stat_q & ~apb_req.pwdata[PORT_COUNT-1:0];
		int_stat_d = int_stat_d | evt;
		irq_d = |(int_stat_d & int_en_d);
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			int_stat_q <= '0;
			int_en_q <= '0;
			irq <= 1'b0;
		end
		else if (cken)
		begin
			prdata <= prdata_d;
			pready <= pready_d;
			pslverr <= pslverr_d;
			int_stat_q <= int_stat_d;
			int_en_q <= int_en_d;
			irq <= irq_d;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	for (genvar g = 0; g < PORT_COUNT; g++)
	begin : g_chk
		logic in_resync;
		assign in_resync = (phase_q[g] == PH_RESYNC) && (tmr_q[g] == '0);
		AST_RESUME_SEQ:
		assert property (@(posedge pclk) disable iff (!presetn)
			$rose(chg_q[g][CHG_RESUME]) |-> $past(in_resync))
			else $error("resume change set outside resync end");
		AST_RESET_CLEARS_RESUME:
		assert property (@(posedge pclk) disable iff (!presetn)
			$rose(chg_q[g][CHG_RESET]) |-> !chg_q[g][CHG_RESUME])
			else $error("resume change survived reset change");
		AST_ENABLE_LOST:
		assert property (@(posedge pclk) disable iff (!presetn)
			$rose(chg_q[g][CHG_ENLOST]) |-> $past(active_q[g]) && !active_q[g])
			else $error("enable-lost set without enable falling");
		AST_NO_LOST_ON_WRITE:
		assert property (@(posedge pclk) disable iff (!presetn)
			cken && pend_q[g][W_EN_CLR] && !xact_busy[g] && active_q[g] && power_q[g]
			&& present_d[g] && !pins_s[g].fault && !chg_q[g][CHG_ENLOST]
			|=> !active_q[g] && !chg_q[g][CHG_ENLOST])
			else $error("driver disable flagged as enable loss");
		AST_ATTACH_EVENT:
		assert property (@(posedge pclk) disable iff (!presetn)
			cken && (present_d[g] != present_q[g]) && !fixed_s[g] |=> chg_q[g][CHG_ATTACH])
			else $error("attach change missed");
		AST_CMD_DETACHED:
		assert property (@(posedge pclk) disable iff (!presetn)
			cken && !xact_busy[g] && pend_q[g][W_RST_SET] && !present_q[g]
			|=> chg_q[g][CHG_ATTACH] && !rst_q[g])
			else $error("reset on detached port not redirected");
		AST_FIXED_QUIET:
		assert property (@(posedge pclk) disable iff (!presetn)
			cken && fixed_s[g] && !announce_q && (pend_q[g] == '0) && !chg_q[g][CHG_ATTACH]
			|=> !chg_q[g][CHG_ATTACH])
			else $error("fixed port flagged attach outside announce");
		AST_W1C:
		assert property (@(posedge pclk) disable iff (!presetn)
			cken && wr_hit[g] && apb_req.pwdata[CHG_LSB + CHG_ATTACH] && !set_a[g][CHG_ATTACH]
			|=> !chg_q[g][CHG_ATTACH])
			else $error("attach change not cleared by one");
		AST_W0_KEEPS:
		assert property (@(posedge pclk) disable iff (!presetn)
			cken && wr_hit[g] && !apb_req.pwdata[CHG_LSB + CHG_ENLOST] && chg_q[g][CHG_ENLOST]
			|=> chg_q[g][CHG_ENLOST])
			else $error("enable-lost cleared by zero");
		AST_SLOW_READ:
		assert property (@(posedge pclk) disable iff (!presetn)
			cken && access && !pready && !apb_req.pwrite
			&& (apb_req.paddr == rhpc_reg_addr(IDX_PORT1 + 8'(g)))
			|=> prdata[BIT_SLOW] == $past(slow_q[g]))
			else $error("slow-attach read wrong");
		AST_POWER_OFF:
		assert property (@(posedge pclk) disable iff (!presetn)
			cken && !xact_busy[g] && pend_q[g][W_PWR_OFF] |=> !power_q[g])
			else $error("power off command ignored");
		AST_RESET_END:
		assert property (@(posedge pclk) disable iff (!presetn)
			$rose(chg_q[g][CHG_RESET]) |-> $fell(rst_q[g]))
			else $error("reset change without reset ending");
		AST_DEFER:
		assert property (@(posedge pclk) disable iff (!presetn)
			cken && xact_busy[g] && pend_q[g][W_PWR_OFF] && power_q[g] && !pins_s[g].ocur
			|=> power_q[g])
			else $error("power write applied during transaction");
		AST_OCUR:
		assert property (@(posedge pclk) disable iff (!presetn)
			cken && pins_s[g].ocur |=> !power_q[g])
			else $error("overcurrent left power on");
	end
endmodule
`default_nettype wire

// ==== test/rhpc_dev_model.sv ====
// Behavioural USB device model for both downstream ports
`default_nettype none
module rhpc_dev_model
	import rhpc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [rhpc_pkg::PORT_COUNT-1:0] attach,
	input wire logic [rhpc_pkg::PORT_COUNT-1:0] slow,
	input wire logic [rhpc_pkg::PORT_COUNT-1:0] ocur,
	input wire logic [rhpc_pkg::PORT_COUNT-1:0] fault,
	input wire logic [rhpc_pkg::PORT_COUNT-1:0] wake,
	output var rhpc_pkg::rhpc_pin_t [rhpc_pkg::PORT_COUNT-1:0] pins
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pins change only after an edge, like a real cable event
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pins <= '0;
		else
			for (int i = 0; i < PORT_COUNT; i++)
				pins[i] <= '{present: attach[i], slow: slow[i], ocur: ocur[i],
					fault: fault[i], wake: wake[i]};
	end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking testbench for the root hub port change logic
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import rhpc_pkg::*;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	localparam logic [11:0] P1 = 12'h054;
	localparam logic [11:0] P2 = 12'h058;
	localparam logic [11:0] ISTAT = 12'h080;
	localparam logic [11:0] ICLR = 12'h084;
	localparam logic [11:0] IEN = 12'h088;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	rhpc_apb_req_t req = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [1:0] port_power;
	logic [1:0] port_reset_drive;
	logic [1:0] port_resume_drive;
	rhpc_pin_t [1:0] pins;
	logic [1:0] attach = 2'h0;
	logic [1:0] slow = 2'h0;
	logic [1:0] ocur = 2'h0;
	logic [1:0] fault = 2'h0;
	logic [1:0] wake = 2'h0;
	logic [1:0] xact_busy = 2'h0;
	logic cken = 1'b1;
	// Port 2 is the non-removable one
	logic [1:0] fixed = 2'h2;
	logic [31:0] rdat;
	logic rerr;
	int errors = 0;
	int tests_run = 0;
	always #5 pclk = ~pclk;
	// Small timer values keep the run short
	rhpc_top #(.RESET_CYCLES(20), .RESUME_CYCLES(30), .EOP_CYCLES(3), .RESYNC_CYCLES(10))
	rhpc_top_inst (.pclk(pclk), .presetn(presetn), .cken(cken), .apb_req(req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .port_pins(pins),
		.fixed_attach_mask(fixed), .xact_busy(xact_busy), .irq(irq),
		.port_power(port_power), .port_reset_drive(port_reset_drive),
		.port_resume_drive(port_resume_drive));
	rhpc_dev_model rhpc_dev_model_inst (.pclk(pclk), .presetn(presetn), .attach(attach),
		.slow(slow), .ocur(ocur), .fault(fault), .wake(wake), .pins(pins));
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", n, e, g);
			errors++;
		end
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// Read data and error are taken only at the edge that sees pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			chk("pready wait", 1'h1, 1'h0);
		rdat = prdata;
		rerr = pslverr;
		req <= '0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_attach();
		wr(P1, 32'h100);
		attach[0] <= 1'b1;
		slow[0] <= 1'b1;
		waitc(6);
		rd(P1);
		chk("p1 present", 1'h1, rdat[0]);
		chk("p1 slow", 1'h1, rdat[9]);
		chk("p1 attach chg", 1'h1, rdat[16]);
		wr(P1, 32'h0);
		rd(P1);
		chk("p1 attach chg kept", 1'h1, rdat[16]);
		wr(P1, 32'h10000);
		rd(P1);
		chk("p1 attach chg clr", 1'h0, rdat[16]);
		rd(P2);
		chk("p2 announce", 1'h1, rdat[16]);
		wr(P2, 32'h10000);
		wr(P2, 32'h100);
		attach[1] <= 1'b1;
		waitc(6);
		rd(P2);
		chk("p2 present", 1'h1, rdat[0]);
		chk("p2 fixed no chg", 1'h0, rdat[16]);
	endtask
	task automatic t_reset_resume();
		wr(P1, 32'h10);
		waitc(3);
		chk("p1 reset drive", 1'h1, port_reset_drive[0]);
		waitc(40);
		rd(P1);
		chk("p1 reset bit", 1'h0, rdat[4]);
		chk("p1 enabled", 1'h1, rdat[1]);
		chk("p1 reset chg", 1'h1, rdat[20]);
		wr(P1, 32'h4);
		wr(P1, 32'h8);
		waitc(20);
		chk("p1 resume drive", 1'h1, port_resume_drive[0]);
		rd(P1);
		chk("p1 resume early", 1'h0, rdat[18]);
		waitc(60);
		rd(P1);
		chk("p1 suspend", 1'h0, rdat[2]);
		chk("p1 resume chg", 1'h1, rdat[18]);
		wr(P1, 32'h100000);
		wr(P1, 32'h10);
		waitc(40);
		rd(P1);
		chk("p1 resume chg gone", 1'h0, rdat[18]);
		chk("p1 reset chg again", 1'h1, rdat[20]);
		// Remote wake from the device starts the same resume sequence
		wr(P1, 32'h4);
		wake[0] <= 1'b1;
		waitc(6);
		wake[0] <= 1'b0;
		chk("p1 wake resume drive", 1'h1, port_resume_drive[0]);
		waitc(60);
		rd(P1);
		chk("p1 wake suspend", 1'h0, rdat[2]);
		chk("p1 wake resume chg", 1'h1, rdat[18]);
	endtask
	task automatic t_enable();
		wr(P1, 32'h1f0000);
		fault[0] <= 1'b1;
		waitc(5);
		fault[0] <= 1'b0;
		waitc(3);
		rd(P1);
		chk("p1 enable dropped", 1'h0, rdat[1]);
		chk("p1 enlost chg", 1'h1, rdat[17]);
		wr(P1, 32'h20000);
		wr(P1, 32'h2);
		rd(P1);
		chk("p1 enable set", 1'h1, rdat[1]);
		wr(P1, 32'h1);
		waitc(3);
		rd(P1);
		chk("p1 enable cleared", 1'h0, rdat[1]);
		chk("p1 enlost by write", 1'h0, rdat[17]);
	endtask
	task automatic t_detach();
		logic [31:0] cmd [3];
		cmd = '{32'h10, 32'h2, 32'h4};
		wr(P1, 32'h1f0000);
		attach[0] <= 1'b0;
		waitc(6);
		rd(P1);
		chk("p1 gone", 1'h0, rdat[0]);
		chk("p1 detach chg", 1'h1, rdat[16]);
		foreach (cmd[i])
		begin
			wr(P1, 32'h10000);
			wr(P1, cmd[i]);
			waitc(3);
			rd(P1);
			chk("p1 cmd on detached chg", 1'h1, rdat[16]);
			chk("p1 cmd not applied", 1'h0, rdat[4] | rdat[2] | rdat[1]);
		end
	endtask
	task automatic t_power();
		xact_busy[0] <= 1'b1;
		wr(P1, 32'h200);
		waitc(5);
		rd(P1);
		chk("p1 power held", 1'h1, rdat[8]);
		xact_busy[0] <= 1'b0;
		waitc(3);
		rd(P1);
		chk("p1 power off", 1'h0, rdat[8]);
		chk("p1 power pin", 1'h0, port_power[0]);
		wr(P1, 32'h100);
		wr(P1, 32'h0);
		rd(P1);
		chk("p1 power kept", 1'h1, rdat[8]);
		ocur[0] <= 1'b1;
		waitc(5);
		chk("p1 ocur power", 1'h0, port_power[0]);
		ocur[0] <= 1'b0;
		waitc(5);
	endtask
	task automatic t_irq();
		wr(P1, 32'h1f0000);
		wr(P2, 32'h1f0000);
		wr(ICLR, 32'h3);
		wr(IEN, 32'h1);
		waitc(2);
		chk("irq idle", 1'h0, irq);
		wr(P1, 32'h100);
		attach[0] <= 1'b1;
		waitc(6);
		chk("irq raised", 1'h1, irq);
		rd(ISTAT);
		chk("int stat", 32'h1, rdat);
		rd(IEN);
		chk("int en", 32'h1, rdat);
		wr(IEN, 32'h0);
		waitc(2);
		chk("irq masked", 1'h0, irq);
		wr(ICLR, 32'h1);
		rd(ISTAT);
		chk("int stat clr", 32'h0, rdat);
		rd(ICLR);
		chk("int clr reads", 32'h0, rdat);
		rd(12'h0fc);
		chk("unmapped err", 1'h1, rerr);
		chk("unmapped data", 32'h0, rdat);
	endtask
	// Clock enable low must hold every flop, synchronisers included
	task automatic t_freeze();
		cken <= 1'b0;
		ocur[0] <= 1'b1;
		waitc(8);
		chk("frozen power", 1'h1, port_power[0]);
		cken <= 1'b1;
		waitc(5);
		chk("thawed power", 1'h0, port_power[0]);
		ocur[0] <= 1'b0;
		waitc(5);
	endtask
	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial
	begin
		waitc(16);
		presetn <= 1'b1;
		waitc(10);
		t_attach();
		t_reset_resume();
		t_enable();
		t_detach();
		t_power();
		t_irq();
		t_freeze();
		test_done();
	end
	// Whole sequence needs well under 2000 cycles
	initial
	begin
		waitc(20000);
		errors++;
		test_done();
	end
endmodule
`default_nettype wire
